// File: three_phase_motor_pwm.sv
/*
  Three-phase center-based PWM unit with four output pairs, dead time,
  single or double update, polarity select, trip input and pattern modes.
  Assumes a 25 MHz clk_sys, a classic Wishbone master and an external
  trip pin that is asynchronous to clk_sys.
*/
// How it works
// - Edges placed on whole clk_sys cycles
// - Sixteen-bit up/down counter centers each pulse
// - Each channel has its own duty register
// - Period and dead time are software registers
// - Signed duty gives clean full on/off
// - Low trip pin forces outputs off asynchronously
// - Four high-side plus four low-side outputs
// - Software selects active-high or active-low outputs
// - Three-phase complementary waveform generator
// - Pattern mask builds commutation sequences
// - Reluctance mode drives high sides only
// - Fractional duty bits dither one extra count
module three_phase_motor_pwm
  import pwm_pkg::*;
#(
  parameter int CH     = 4,
  parameter int CNT_W  = 16,
  parameter int FRAC_W = 3,
  parameter int DEAD_W = 10
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        trip_n,
  output logic [CH-1:0]    pwm_hi,
  output logic [CH-1:0]    pwm_lo
);

  // ----------------------------------------------------------------
  // Registers and shadows
  // ----------------------------------------------------------------
  ctrl_s                 ctrl_q;
  logic [CNT_W-1:0]      per_sh_q, per_q;
  logic [DEAD_W-1:0]     dead_q;
  logic [31:0]           duty_sh_q [CH];
  logic [31:0]           duty_q    [CH];
  logic [2*CH-1:0]       pat_sh_q, pat_q;
  logic                  trip_latch_q;
  logic [CNT_W-1:0]      cnt_q;
  logic                  up_q;
  logic [1:0]            trip_sync_q;
  logic [CH-1:0]         raw, hi_on, lo_on;
  logic [CH-1:0]         hi_act_q, lo_act_q, hi_off0_q, lo_off0_q, hi_off1_q, lo_off1_q;
  logic                  wr_stb, rd_stb, start, mid, reload, run;
  logic [31:0]           rdata;

  // Writes land on the edge where the master sees ack high
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // ----------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, then drop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      OFF_CTRL:    rdata = {27'h0, ctrl_q};
      OFF_PERIOD:  rdata = {16'h0, per_sh_q};
      OFF_DEAD:    rdata = {22'h0, dead_q};
      OFF_PATTERN: rdata = {24'h0, pat_sh_q};
      OFF_STATUS:  rdata = {cnt_q, 14'h0, up_q, trip_latch_q};
      default: begin
        for (int i = 0; i < CH; i++) begin
          if (wb_adr_i == OFF_DUTY0 + 8'(4 * i)) begin
            rdata = duty_sh_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      wb_dat_o <= rdata;
    end
  end

  // Narrow registers and shadows; only byte lane 0 enables them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q   <= CTRL_RST;
      per_sh_q <= PERIOD_RST;
      dead_q   <= DEAD_RST;
      pat_sh_q <= PATTERN_RST;
    end else if (wr_stb && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFF_CTRL:    ctrl_q   <= ctrl_s'(wb_dat_i[4:0]);
        OFF_PERIOD:  per_sh_q <= wb_dat_i[CNT_W-1:0];
        OFF_DEAD:    dead_q   <= wb_dat_i[DEAD_W-1:0];
        OFF_PATTERN: pat_sh_q <= wb_dat_i[2*CH-1:0];
        default: ;
      endcase
    end
  end

  // Duty shadows, one word per channel, byte lanes honoured
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CH; i++) begin
        duty_sh_q[i] <= 32'h0000_0000;
      end
    end else if (wr_stb) begin
      for (int i = 0; i < CH; i++) begin
        if (wb_adr_i == OFF_DUTY0 + 8'(4 * i)) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              duty_sh_q[i][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Trip: synchronised copy latches a sticky flag; write 1 clears it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      trip_sync_q <= 2'b11;
    end else begin
      trip_sync_q <= {trip_sync_q[0], trip_n};
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      trip_latch_q <= 1'b0;
    end else if (!trip_sync_q[1]) begin
      trip_latch_q <= 1'b1;
    end else if (wr_stb && wb_adr_i == OFF_STATUS && wb_sel_i[0] && wb_dat_i[0]) begin
      trip_latch_q <= 1'b0;
    end
  end

  assign run = ctrl_q.enable & ~trip_latch_q;

  // ----------------------------------------------------------------
  // Up/down time base: 0 .. period .. 1, one step per clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      up_q  <= 1'b1;
    end else if (!run || per_q == '0) begin
      cnt_q <= '0;
      up_q  <= 1'b1;
    end else if (up_q && cnt_q >= per_q) begin
      cnt_q <= cnt_q - 1'b1;
      up_q  <= (cnt_q == CNT_W'(1));
    end else if (up_q) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      cnt_q <= cnt_q - 1'b1;
      up_q  <= (cnt_q == CNT_W'(1));
    end
  end

  assign start  = up_q & (cnt_q == '0);
  assign mid    = up_q & (cnt_q >= per_q) & (per_q != '0);
  assign reload = start | (ctrl_q.dbl_update & mid);

  // Active copies follow the shadows only at reload points or while stopped, so a
  // half-written set of duties never reaches the outputs between reload points
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      per_q <= PERIOD_RST;
      pat_q <= PATTERN_RST;
      for (int i = 0; i < CH; i++) begin
        duty_q[i] <= 32'h0000_0000;
      end
    end else if (reload || !run) begin
      per_q <= per_sh_q;
      pat_q <= pat_sh_q;
      for (int i = 0; i < CH; i++) begin
        duty_q[i] <= duty_sh_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel compare, dither and dead time
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CH; g++) begin : g_ch
    logic [FRAC_W-1:0]   acc_q;
    logic                carry_q;
    logic [FRAC_W:0]     acc_sum;
    logic signed [16:0]  duty_eff;
    logic [DEAD_W-1:0]   dt_q;
    logic                raw_prev_q;
    logic                settled;

    // Fractional bits carry one extra count, two more active cycles, on some periods
    assign acc_sum = {1'b0, acc_q} + {1'b0, duty_q[g][DUTY_INT_LSB-1 -: FRAC_W]};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        acc_q   <= '0;
        carry_q <= 1'b0;
      end else if (start && run) begin
        acc_q   <= acc_sum[FRAC_W-1:0];
        carry_q <= acc_sum[FRAC_W];
      end
    end

    // Signed compare: duty <= 0 is full off, duty > period is full on
    assign duty_eff = 17'(signed'(duty_q[g][31:DUTY_INT_LSB])) + 17'(carry_q);
    assign raw[g]   = run & (signed'({1'b0, cnt_q}) < duty_eff);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        dt_q       <= '0;
        raw_prev_q <= 1'b0;
      end else begin
        raw_prev_q <= raw[g];
        if (raw[g] != raw_prev_q) begin
          dt_q <= '0;
        end else if (dt_q < dead_q) begin
          dt_q <= dt_q + 1'b1;
        end
      end
    end

    // Neither side turns on until the edge has aged by the dead time
    assign settled = (raw[g] == raw_prev_q) & (dt_q >= dead_q);

    always_comb begin
      hi_on[g] = raw[g] & settled & pat_q[2*g];
      lo_on[g] = ~raw[g] & settled & pat_q[2*g+1] & run;
      if (ctrl_q.mode == MODE_RELUCTANCE) begin
        lo_on[g] = 1'b0;
      end else if (ctrl_q.mode == MODE_THREE_PHASE) begin
        hi_on[g] = raw[g] & settled;
        lo_on[g] = ~raw[g] & settled & run;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hi_act_q <= '0;
      lo_act_q <= '0;
    end else begin
      hi_act_q <= hi_on;
      lo_act_q <= lo_on;
    end
  end

  // ----------------------------------------------------------------
  // Output stage: one flop pair per polarity, each forced to its off level straight
  // from the trip pin so the off level needs no clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst or negedge trip_n) begin
    if (sys_rst || !trip_n) begin
      hi_off0_q <= '0;
      lo_off0_q <= '0;
    end else begin
      hi_off0_q <= hi_act_q;
      lo_off0_q <= lo_act_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst or negedge trip_n) begin
    if (sys_rst || !trip_n) begin
      hi_off1_q <= '1;
      lo_off1_q <= '1;
    end else begin
      hi_off1_q <= ~hi_act_q;
      lo_off1_q <= ~lo_act_q;
    end
  end

  // Polarity picks the flop set whose reset value is its off level
  assign pwm_hi = ctrl_q.act_low ? hi_off1_q : hi_off0_q;
  assign pwm_lo = ctrl_q.act_low ? lo_off1_q : lo_off0_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  for (genvar k = 0; k < CH; k++) begin : g_chk
    a_pair_exclusive: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(hi_act_q[k] && lo_act_q[k])) else $error("pair both active");
  end
  a_trip_outputs_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !trip_n |-> (pwm_hi == {CH{ctrl_q.act_low}}) && (pwm_lo == {CH{ctrl_q.act_low}}))
    else $error("outputs not off during trip");
  a_trip_latch_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !trip_sync_q[1] |=> trip_latch_q) else $error("trip not latched");
  a_cnt_bounded: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run && per_q != '0 |-> cnt_q <= per_q) else $error("counter above period");
  a_cnt_step_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run && $past(run) && per_q == $past(per_q) && per_q != '0 && $past(per_q) != '0
    |-> (cnt_q == $past(cnt_q) + 1'b1) || (cnt_q == $past(cnt_q) - 1'b1))
    else $error("counter step not one");
  a_single_no_mid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run && !ctrl_q.dbl_update && !start && per_sh_q != per_q |=> $stable(per_q))
    else $error("reload away from period start");
  a_full_off_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $signed(duty_q[1][31:DUTY_INT_LSB]) < 0 |-> !raw[1])
    else $error("negative duty gave pulse");
  a_reluct_low_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl_q.mode == MODE_RELUCTANCE && $past(ctrl_q.mode) == MODE_RELUCTANCE
    |-> lo_act_q == '0) else $error("low side on in reluctance mode");
  a_wb_ack_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dead_gap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(hi_act_q[0]) && dead_q != '0 |=> !lo_act_q[0])
    else $error("low side on with no dead time");

endmodule : three_phase_motor_pwm

// File: pwm_pkg.sv
/*
  Shared constants and types of the three-phase center-based PWM block:
  register offsets, control fields, reset values and the mode encoding.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
package pwm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_PERIOD  = 8'h04;
  localparam logic [7:0] OFF_DEAD    = 8'h08;
  localparam logic [7:0] OFF_DUTY0   = 8'h0c; // Duty n at 0x0c + 4*n
  localparam logic [7:0] OFF_PATTERN = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          DUTY_INT_LSB = 16; // Integer duty in [31:16]
  localparam int          STAT_CNT_LSB = 16; // Counter shown in [31:16]
  localparam logic [15:0] PERIOD_RST   = 16'h0100;
  localparam logic [9:0]  DEAD_RST     = 10'h004;
  localparam logic [7:0]  PATTERN_RST  = 8'hff;

  // Switching pattern modes
  typedef enum logic [1:0] {
    MODE_THREE_PHASE = 2'h0,
    MODE_COMMUTATED  = 2'h1,
    MODE_RELUCTANCE  = 2'h2
  } mode_e;

  // Control word, low bits of CTRL
  typedef struct packed {
    mode_e mode;       // [4:3]
    logic  act_low;    // [2] Outputs active low
    logic  dbl_update; // [1] Reload at start and midpoint
    logic  enable;     // [0]
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{mode: MODE_THREE_PHASE, act_low: 1'b0,
                                 dbl_update: 1'b0, enable: 1'b0};

endpackage : pwm_pkg

// File: gate_driver_model.sv
/*
  Gate driver model for one three-phase inverter: watches the four
  drive pairs for shoot-through and pulls the trip pin on a fault.
  Assumes the bench keeps act_low equal to the polarity it programmed.
*/
module gate_driver_model (
  input  wire logic       clk_sys,
  input  wire logic       fault,
  input  wire logic       act_low,
  input  wire logic       mon_en,
  input  wire logic [3:0] pwm_hi,
  input  wire logic [3:0] pwm_lo,
  output logic            trip_n,
  output int              overlaps
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Fault pin and leg monitor
  // ----------------------------------------------------------------
  // Desaturation pulls trip low with no clock involved
  assign trip_n = !fault;
  // Both switches of a leg on would short the bus
  initial overlaps = 0;
  always @(negedge clk_sys) begin
    if (mon_en && (((pwm_hi ^ {4{act_low}}) & (pwm_lo ^ {4{act_low}})) != 4'h0)) begin
      overlaps++;
    end
  end
endmodule : gate_driver_model

// File: three_phase_motor_pwm_test.sv
/*
  Self-checking bench of the PWM unit: Wishbone tasks, on-time counts
  per output over four periods, polarity, trip, update and modes.
  Assumes pwm_pkg and the gate driver model are compiled first.
*/
module three_phase_motor_pwm_test
  import pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fault = 1'b0, act = 1'b0, mon_en = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, wb_dat_o;
  logic        wb_ack_o, trip_n;
  logic [3:0]  pwm_hi, pwm_lo;
  int          overlaps, n_mismatch = 0, checks = 0;
  int          hi_n[4], lo_n[4], rise_n[4];
  always #20 clk_sys = ~clk_sys;
  three_phase_motor_pwm three_phase_motor_pwm_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trip_n(trip_n),
    .pwm_hi(pwm_hi), .pwm_lo(pwm_lo));
  gate_driver_model gate_driver_model_i (.clk_sys(clk_sys), .fault(fault), .act_low(act),
    .mon_en(mon_en), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .trip_n(trip_n), .overlaps(overlaps));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check_val(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic check_rng(string name, int lo, int hi, int got);
    checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng
  // Request held until ack is sampled high; data taken at that edge
  task automatic wb_xfer(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      $display("[ERR] wb_ack expected 1 seen 0");
      end_sim();
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb_xfer
  task automatic reg_chk(string name, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    check_val(name, e, rdat & m);
  endtask : reg_chk
  // Active cycles over four periods of N=8; one window fits any phase
  task automatic measure();
    logic [3:0] prev;
    logic       unk = 1'b0;
    repeat (40) @(posedge clk_sys);
    mon_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      hi_n[c] = 0;
      lo_n[c] = 0;
      rise_n[c] = 0;
    end
    @(negedge clk_sys);
    prev = pwm_hi ^ {4{act}};
    repeat (64) begin
      @(negedge clk_sys);
      for (int c = 0; c < 4; c++) begin
        hi_n[c] += int'(pwm_hi[c] ^ act);
        lo_n[c] += int'(pwm_lo[c] ^ act);
        rise_n[c] += int'((pwm_hi[c] ^ act) & !prev[c]);
      end
      prev = pwm_hi ^ {4{act}};
      unk |= $isunknown({pwm_hi, pwm_lo});
    end
    mon_en <= 1'b0;
    check_val("pwm known", 32'h0, {31'h0, unk});
  endtask : measure
  // Duties 4, -3, 9, 2 with one dead cycle; dead time may trim edges
  task automatic chk_three();
    int hl[4] = '{20, 0, 64, 4};
    int hh[4] = '{28, 0, 64, 12};
    int ll[4] = '{28, 64, 0, 44};
    int lh[4] = '{36, 64, 0, 52};
    for (int c = 0; c < 4; c++) begin
      check_rng("hi active", hl[c], hh[c], hi_n[c]);
      check_rng("lo active", ll[c], lh[c], lo_n[c]);
    end
    check_rng("hi0 rises", 4, 4, rise_n[0]);
  endtask : chk_three
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_chk("ctrl", OFF_CTRL, 32'h1f, 32'h0);
    reg_chk("period", OFF_PERIOD, 32'hffff, {16'h0, PERIOD_RST});
    reg_chk("dead", OFF_DEAD, 32'h3ff, {22'h0, DEAD_RST});
    reg_chk("pattern", OFF_PATTERN, 32'hff, {24'h0, PATTERN_RST});
    reg_chk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    check_val("pwm idle", 32'h0, {24'h0, pwm_hi, pwm_lo});
    $display("test reset done");
    wb_xfer(1'b1, OFF_PERIOD, 32'h8);
    wb_xfer(1'b1, OFF_DEAD, 32'h1);
    wb_xfer(1'b1, OFF_DUTY0, 32'h00040000);
    wb_xfer(1'b1, OFF_DUTY0 + 8'h04, 32'hfffd0000);
    wb_xfer(1'b1, OFF_DUTY0 + 8'h08, 32'h00090000);
    wb_xfer(1'b1, OFF_DUTY0 + 8'h0c, 32'h00020000);
    reg_chk("duty1", OFF_DUTY0 + 8'h04, 32'hffffe000, 32'hfffd0000);
    wb_xfer(1'b1, OFF_CTRL, 32'h1);
    measure();
    chk_three();
    $display("test three phase done");
    act = 1'b1;
    wb_xfer(1'b1, OFF_CTRL, 32'h5);
    measure();
    chk_three();
    check_val("hi1 level", 32'h1, {31'h0, pwm_hi[1]});
    $display("test polarity done");
    // Trip with active-low outputs: off level is high
    @(posedge clk_sys);
    fault <= 1'b1;
    #1;
    check_val("trip hi", 32'hf, {28'h0, pwm_hi});
    check_val("trip lo", 32'hf, {28'h0, pwm_lo});
    repeat (5) @(posedge clk_sys);
    reg_chk("trip flag", OFF_STATUS, 32'h1, 32'h1);
    wb_xfer(1'b1, OFF_STATUS, 32'h1);
    reg_chk("trip held", OFF_STATUS, 32'h1, 32'h1);
    check_val("trip hold", 32'hf, {28'h0, pwm_hi});
    @(posedge clk_sys);
    fault <= 1'b0;
    repeat (3) @(posedge clk_sys); // Synchroniser must see the release first
    wb_xfer(1'b1, OFF_STATUS, 32'h1);
    reg_chk("trip clear", OFF_STATUS, 32'h1, 32'h0);
    measure();
    chk_three();
    $display("test trip done");
    act = 1'b0;
    wb_xfer(1'b1, OFF_CTRL, 32'h3);
    measure();
    chk_three();
    $display("test double update done");
    // Period change while running single update, then back to eight
    wb_xfer(1'b1, OFF_CTRL, 32'h1);
    wb_xfer(1'b1, OFF_PERIOD, 32'h4);
    measure();
    check_rng("n4 hi0", 40, 40, hi_n[0]);
    check_rng("n4 lo0", 0, 0, lo_n[0]);
    $display("test period done");
    wb_xfer(1'b1, OFF_PATTERN, 32'h1);
    wb_xfer(1'b1, OFF_CTRL, 32'h9);
    wb_xfer(1'b1, OFF_PERIOD, 32'h8);
    measure();
    check_rng("cm hi0", 20, 28, hi_n[0]);
    for (int c = 0; c < 4; c++) begin
      check_rng("cm lo", 0, 0, lo_n[c]);
      check_rng("cm hi", 0, 0, (c == 0) ? 0 : hi_n[c]);
    end
    $display("test commutated done");
    wb_xfer(1'b1, OFF_PATTERN, 32'hff);
    wb_xfer(1'b1, OFF_CTRL, 32'h11);
    measure();
    check_rng("rm hi2", 64, 64, hi_n[2]);
    for (int c = 0; c < 4; c++) begin
      check_rng("rm lo", 0, 0, lo_n[c]);
    end
    $display("test reluctance done");
    wb_xfer(1'b1, OFF_CTRL, 32'h0);
    measure();
    check_rng("off hi2", 0, 0, hi_n[2]);
    check_val("overlap", 32'h0, overlaps);
    $display("test disable done");
    end_sim();
  end
endmodule : three_phase_motor_pwm_test
